/* core/fbi_pkg.sv */
// constants, types and register map of the flash bus host controller
// Contract
// - alteration needs setup write then confirm; program sends the data byte as its second write instead
// - host selects read mode before reading
// - data driven only on select, gate low
// - host writes read array after alteration; none follows an erase that was suspended and resumed
// - command write pin levels held by host
package fbi_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_NS = 10;

	// least times round up, never below one cycle
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int T_SETUP_NS = 20;
	localparam int T_WE_LOW_NS = 50;
	localparam int T_HOLD_NS = 20;
	localparam int T_ACCESS_NS = 90;
	localparam int T_BUSY_NS = 200;
	localparam int T_WAKE_NS = 1000;
	localparam logic [7:0] SETUP_CYC = 8'(ns_to_cyc(T_SETUP_NS));
	localparam logic [7:0] WE_LOW_CYC = 8'(ns_to_cyc(T_WE_LOW_NS));
	localparam logic [7:0] HOLD_CYC = 8'(ns_to_cyc(T_HOLD_NS));
	localparam logic [7:0] ACCESS_CYC = 8'(ns_to_cyc(T_ACCESS_NS));
	localparam logic [7:0] BUSY_CYC = 8'(ns_to_cyc(T_BUSY_NS));
	localparam logic [7:0] WAKE_CYC = 8'(ns_to_cyc(T_WAKE_NS));

	// ****************************************
	// register map and fields
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CONFIG = 8'h14;
	localparam int CTRL_OP_MSB = 3;
	localparam int CFG_PD_BIT = 0;
	localparam int CFG_VPP_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RB_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	localparam int STAT_PD_BIT = 3;
	localparam int STAT_MODE_LSB = 4;
	localparam logic CFG_PD_RESET = 1'b0;
	localparam logic CFG_VPP_RESET = 1'b0;
	localparam logic [19:0] ADDR_RESET = 20'h0_0000;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ****************************************
	// flash address and commands
	// ****************************************
	localparam int FA_W = 20;
	localparam int BLOCK_LSB = 16;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_IDENT = 4'h1,
		OP_STATUS = 4'h2,
		OP_PROGRAM = 4'h3,
		OP_ERASE = 4'h4,
		OP_SUSPEND = 4'h5,
		OP_RESUME = 4'h6,
		OP_CLEAR = 4'h7
	} op_e;

	typedef enum logic [1:0] {
		MODE_ARRAY = 2'b00,
		MODE_IDENT = 2'b01,
		MODE_STATUS = 2'b10
	} mode_e;

	typedef enum logic [2:0] {
		Q_IDLE = 3'b000,
		Q_MODE = 3'b001,
		Q_W1 = 3'b010,
		Q_W2 = 3'b011,
		Q_WAIT = 3'b100,
		Q_FF = 3'b101,
		Q_READ = 3'b110
	} seq_e;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_WSET = 3'b001,
		B_WLOW = 3'b010,
		B_WHOLD = 3'b011,
		B_RACC = 3'b100
	} bus_e;

	typedef struct packed {
		logic chip_select_n;
		logic output_gate_n;
		logic write_strobe_n;
		logic powerdown_reset_n;
		logic vpp_enable;
		logic [FA_W-1:0] address;
		logic [7:0] data_lines_out;
		logic data_lines_oe_n;
	} flash_pins_s;

endpackage

/* core/fbi_host.sv */
// apb controlled host that drives the parallel flash pins
`timescale 1ns/10ps
module fbi_host (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// flash pins
	output fbi_pkg::flash_pins_s FLASH_O,
	input wire logic [7:0] DATA_LINES_I,
	input wire logic READY_BUSY_I
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic fbi_pkg::mode_e want_of(input fbi_pkg::op_e op);
		unique case (op)
			fbi_pkg::OP_IDENT: return fbi_pkg::MODE_IDENT;
			fbi_pkg::OP_STATUS: return fbi_pkg::MODE_STATUS;
			default: return fbi_pkg::MODE_ARRAY;
		endcase
	endfunction

	// {chip_select_n, output_gate_n, write_strobe_n, data_lines_oe_n}
	function automatic logic [3:0] ctl_of(input fbi_pkg::bus_e b);
		unique case (b)
			fbi_pkg::B_WSET: return 4'b0110;
			fbi_pkg::B_WLOW: return 4'b0100;
			fbi_pkg::B_WHOLD: return 4'b0110;
			fbi_pkg::B_RACC: return 4'b0011;
			default: return 4'b1111;
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	fbi_pkg::seq_e seq_q, seq_d;
	fbi_pkg::bus_e b_q, b_d;
	fbi_pkg::op_e op_q;
	fbi_pkg::mode_e mode_q, mode_d;
	logic [7:0] cnt_q, cnt_d, wait_q, wake_q;
	logic [19:0] addr_q, fa_q;
	logic [7:0] wdata_q, rdata_q, fd_q;
	logic [3:0] ctl_q;
	logic cfg_pd_q, cfg_vpp_q, done_q, pwd_n_q, vpp_q;
	logic [31:0] prdata_q;
	logic bus_go, bus_wr, bus_done;
	logic [19:0] bus_a;
	logic [7:0] bus_d;

	// ****************************************
	// apb decode
	// ****************************************
	wire apb_setup = PSEL & ~PENABLE;
	wire apb_wr = PSEL & PENABLE & PWRITE;
	wire hit_ctrl = PADDR == fbi_pkg::OFS_CTRL;
	wire hit_addr = PADDR == fbi_pkg::OFS_ADDR;
	wire hit_wdata = PADDR == fbi_pkg::OFS_WDATA;
	wire hit_rdata = PADDR == fbi_pkg::OFS_RDATA;
	wire hit_status = PADDR == fbi_pkg::OFS_STATUS;
	wire hit_config = PADDR == fbi_pkg::OFS_CONFIG;
	wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status
		| hit_config;
	wire waking = wake_q != 8'h00;
	wire busy = (seq_q != fbi_pkg::Q_IDLE) | waking | ~pwd_n_q;
	wire op_legal = ~PWDATA[fbi_pkg::CTRL_OP_MSB];
	// suspend is the one order taken while an erase waits on the part;
	// the supply request ends with it, so keep config supply on to resume
	wire susp_ok = (seq_q == fbi_pkg::Q_WAIT) & (op_q == fbi_pkg::OP_ERASE)
		& (PWDATA[3:0] == fbi_pkg::OP_SUSPEND);
	// no order is taken while the part sleeps or wakes
	wire start_ok = (~busy | susp_ok) & ~cfg_pd_q & op_legal;
	wire start = apb_wr & hit_ctrl & start_ok;
	wire bad_wr = apb_wr & (hit_rdata | (hit_ctrl & ~start_ok));
	wire done_clr = apb_wr & hit_status & PWDATA[fbi_pkg::STAT_DONE_BIT];
	wire [31:0] status_word = {26'h000_0000, mode_q, pwd_n_q ? 1'b0 : 1'b1,
		done_q, READY_BUSY_I, busy};
	wire [31:0] rd_mux =
		hit_ctrl ? {28'h000_0000, op_q} :
		hit_addr ? {12'h000, addr_q} :
		hit_wdata ? {24'h00_0000, wdata_q} :
		hit_rdata ? {24'h00_0000, rdata_q} :
		hit_status ? status_word :
		hit_config ? {30'h0000_0000, cfg_vpp_q, cfg_pd_q} :
		32'h0000_0000;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & (~mapped | bad_wr);
	assign PRDATA = prdata_q;

	// ****************************************
	// operation sequencing
	// ****************************************
	wire fbi_pkg::op_e new_op = fbi_pkg::op_e'(PWDATA[3:0]);
	wire new_read = (new_op == fbi_pkg::OP_READ)
		| (new_op == fbi_pkg::OP_IDENT) | (new_op == fbi_pkg::OP_STATUS);
	// a read goes straight out only when the part is already in its mode
	wire fbi_pkg::seq_e start_seq = ~new_read ? fbi_pkg::Q_W1 :
		(want_of(new_op) != mode_q) ? fbi_pkg::Q_MODE :
		fbi_pkg::Q_READ;
	wire alter = (op_q == fbi_pkg::OP_PROGRAM) | (op_q == fbi_pkg::OP_ERASE);
	// erase targets the block base, only the top nibble matters
	wire [19:0] block_a = {addr_q[19:fbi_pkg::BLOCK_LSB], 16'h0000};
	// identifier reads use only the low address bit
	wire [19:0] ident_a = {19'h0_0000, addr_q[0]};
	wire [7:0] mode_cmd = (want_of(op_q) == fbi_pkg::MODE_IDENT) ?
		fbi_pkg::CMD_IDENT : (want_of(op_q) == fbi_pkg::MODE_STATUS) ?
		fbi_pkg::CMD_READ_STATUS : fbi_pkg::CMD_READ_ARRAY;
	wire [7:0] first_cmd =
		(op_q == fbi_pkg::OP_PROGRAM) ? fbi_pkg::CMD_WRITE_SETUP :
		(op_q == fbi_pkg::OP_ERASE) ? fbi_pkg::CMD_ERASE_SETUP :
		(op_q == fbi_pkg::OP_SUSPEND) ? fbi_pkg::CMD_SUSPEND :
		(op_q == fbi_pkg::OP_RESUME) ? fbi_pkg::CMD_CONFIRM :
		fbi_pkg::CMD_CLEAR_STATUS;
	wire [7:0] second_data = (op_q == fbi_pkg::OP_PROGRAM) ? wdata_q :
		fbi_pkg::CMD_CONFIRM;
	wire b_free = b_q == fbi_pkg::B_IDLE;

	always_comb begin
		seq_d = seq_q;
		bus_go = 1'b0;
		bus_wr = 1'b1;
		bus_a = addr_q;
		bus_d = first_cmd;
		unique case (seq_q)
			fbi_pkg::Q_IDLE: begin
				if (start) begin
					seq_d = start_seq;
				end
			end
			fbi_pkg::Q_MODE: begin
				bus_go = b_free;
				bus_d = mode_cmd;
				if (bus_done) begin
					seq_d = fbi_pkg::Q_READ;
				end
			end
			fbi_pkg::Q_W1: begin
				bus_go = b_free;
				bus_a = (op_q == fbi_pkg::OP_ERASE) ? block_a : addr_q;
				if (bus_done) begin
					// a setup write alone never alters; the data byte (program) or confirm (erase) follows
					seq_d = alter ? fbi_pkg::Q_W2 :
						(op_q == fbi_pkg::OP_SUSPEND) ? fbi_pkg::Q_WAIT :
						fbi_pkg::Q_IDLE;
				end
			end
			fbi_pkg::Q_W2: begin
				bus_go = b_free;
				bus_a = (op_q == fbi_pkg::OP_ERASE) ? block_a : addr_q;
				bus_d = second_data;
				if (bus_done) begin
					seq_d = fbi_pkg::Q_WAIT;
				end
			end
			fbi_pkg::Q_WAIT: begin
				// the part may take a while to pull ready low, so wait first
				if (start) begin
					seq_d = start_seq;
				end else if (wait_q == 8'h00 && READY_BUSY_I) begin
					seq_d = alter ? fbi_pkg::Q_FF : fbi_pkg::Q_IDLE;
				end
			end
			fbi_pkg::Q_FF: begin
				bus_go = b_free;
				bus_d = fbi_pkg::CMD_READ_ARRAY;
				if (bus_done) begin
					seq_d = fbi_pkg::Q_IDLE;
				end
			end
			fbi_pkg::Q_READ: begin
				bus_go = b_free;
				bus_wr = 1'b0;
				bus_a = (op_q == fbi_pkg::OP_IDENT) ? ident_a : addr_q;
				if (bus_done) begin
					seq_d = fbi_pkg::Q_IDLE;
				end
			end
			default: seq_d = fbi_pkg::Q_IDLE;
		endcase
	end

	always_comb begin
		mode_d = mode_q;
		if (!pwd_n_q) begin
			mode_d = fbi_pkg::MODE_ARRAY;
		end else if (bus_done && seq_q == fbi_pkg::Q_MODE) begin
			mode_d = want_of(op_q);
		end else if (bus_done && seq_q == fbi_pkg::Q_W1
			&& op_q != fbi_pkg::OP_CLEAR) begin
			mode_d = fbi_pkg::MODE_STATUS;
		end else if (bus_done && seq_q == fbi_pkg::Q_FF) begin
			mode_d = fbi_pkg::MODE_ARRAY;
		end
	end

	// ****************************************
	// pin cycle engine
	// ****************************************
	wire cnt_zero = cnt_q == 8'h00;

	always_comb begin
		b_d = b_q;
		cnt_d = cnt_zero ? 8'h00 : cnt_q - 8'h01;
		bus_done = 1'b0;
		unique case (b_q)
			fbi_pkg::B_IDLE: begin
				if (bus_go) begin
					b_d = bus_wr ? fbi_pkg::B_WSET : fbi_pkg::B_RACC;
					cnt_d = bus_wr ? fbi_pkg::SETUP_CYC - 8'h01 :
						fbi_pkg::ACCESS_CYC - 8'h01;
				end
			end
			fbi_pkg::B_WSET: begin
				if (cnt_zero) begin
					b_d = fbi_pkg::B_WLOW;
					cnt_d = fbi_pkg::WE_LOW_CYC - 8'h01;
				end
			end
			fbi_pkg::B_WLOW: begin
				if (cnt_zero) begin
					// data stays on the lines past the strobe rise
					b_d = fbi_pkg::B_WHOLD;
					cnt_d = fbi_pkg::HOLD_CYC - 8'h01;
				end
			end
			fbi_pkg::B_WHOLD: begin
				if (cnt_zero) begin
					b_d = fbi_pkg::B_IDLE;
					bus_done = 1'b1;
				end
			end
			fbi_pkg::B_RACC: begin
				if (cnt_zero) begin
					b_d = fbi_pkg::B_IDLE;
					bus_done = 1'b1;
				end
			end
			default: b_d = fbi_pkg::B_IDLE;
		endcase
	end

	wire rd_take = (b_q == fbi_pkg::B_RACC) & cnt_zero;
	wire vpp_d = cfg_vpp_q | ((seq_q != fbi_pkg::Q_IDLE) & alter);

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			seq_q <= fbi_pkg::Q_IDLE;
			b_q <= fbi_pkg::B_IDLE;
			op_q <= fbi_pkg::OP_READ;
			mode_q <= fbi_pkg::MODE_ARRAY;
			cnt_q <= 8'h00;
			wait_q <= 8'h00;
			wake_q <= fbi_pkg::WAKE_CYC;
			addr_q <= fbi_pkg::ADDR_RESET;
			fa_q <= fbi_pkg::ADDR_RESET;
			wdata_q <= fbi_pkg::DATA_RESET;
			rdata_q <= fbi_pkg::DATA_RESET;
			fd_q <= fbi_pkg::DATA_RESET;
			ctl_q <= 4'hF;
			cfg_pd_q <= fbi_pkg::CFG_PD_RESET;
			cfg_vpp_q <= fbi_pkg::CFG_VPP_RESET;
			done_q <= 1'b0;
			pwd_n_q <= 1'b0;
			vpp_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			seq_q <= seq_d;
			b_q <= b_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			ctl_q <= ctl_of(b_d);
			vpp_q <= vpp_d;
			pwd_n_q <= ~cfg_pd_q;
			done_q <= ((seq_q != fbi_pkg::Q_IDLE) & (seq_d == fbi_pkg::Q_IDLE))
				| (done_q & ~done_clr);
			if (seq_d == fbi_pkg::Q_WAIT && seq_q != fbi_pkg::Q_WAIT) begin
				wait_q <= fbi_pkg::BUSY_CYC;
			end else if (wait_q != 8'h00) begin
				wait_q <= wait_q - 8'h01;
			end
			if (!pwd_n_q) begin
				wake_q <= fbi_pkg::WAKE_CYC;
			end else if (waking) begin
				wake_q <= wake_q - 8'h01;
			end
			if (start) begin
				op_q <= new_op;
			end
			if (b_free && bus_go) begin
				fa_q <= bus_a;
				fd_q <= bus_d;
			end
			if (rd_take) begin
				rdata_q <= DATA_LINES_I;
			end
			if (apb_wr && hit_addr) begin
				addr_q <= PWDATA[19:0];
			end
			if (apb_wr && hit_wdata) begin
				wdata_q <= PWDATA[7:0];
			end
			if (apb_wr && hit_config) begin
				cfg_pd_q <= PWDATA[fbi_pkg::CFG_PD_BIT];
				cfg_vpp_q <= PWDATA[fbi_pkg::CFG_VPP_BIT];
			end
			if (apb_setup && !PWRITE) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign FLASH_O = {ctl_q[3], ctl_q[2], ctl_q[1], pwd_n_q, vpp_q, fa_q,
		fd_q, ctl_q[0]};

endmodule

/* test/fbi_checker.sv */
// assertions on the flash pins driven by the host controller
`timescale 1ns/10ps
module fbi_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// apb requests
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	// flash pins
	input wire fbi_pkg::flash_pins_s FLASH_O
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	wire wr = PSEL && PENABLE && PWRITE;
	wire cs = !FLASH_O.chip_select_n;
	wire ws = !FLASH_O.write_strobe_n;
	wire og = !FLASH_O.output_gate_n;
	wire pdn = FLASH_O.powerdown_reset_n;
	// ****************
	// pin relations
	// ****************
	cmd_pins_a: assert property (ws |-> cs && !og && pdn)
		else $error("strobe low with wrong pin levels");
	read_pins_a: assert property (og |-> cs && !ws && pdn)
		else $error("gate low with wrong pin levels");
	no_fight_a: assert property (og |-> FLASH_O.data_lines_oe_n)
		else $error("host drives data lines during a read");
	strobe_len_a: assert property ($rose(ws) |-> ws[*5] ##1 !ws)
		else $error("strobe pulse length wrong");
	setup_time_a: assert property ($rose(ws) |-> $past(cs, 2))
		else $error("strobe fell without setup time");
	data_hold_a: assert property ($fell(ws) |-> cs ##1
		(cs && $stable(FLASH_O.data_lines_out)))
		else $error("data not held after strobe");
	pd_req_a: assert property (wr && PADDR == fbi_pkg::OFS_CONFIG
		&& PWDATA[0] |-> ##2 !pdn)
		else $error("powerdown request not passed to pin");
	vpp_cause_a: assert property ($rose(FLASH_O.vpp_enable)
		|-> $past(wr) || $past(wr, 2))
		else $error("program supply raised without request");
	cover property ($fell(ws));
	cover property (og ##1 !og);
	cover property (!pdn ##1 pdn);
endmodule

bind fbi_host fbi_checker fbi_checker_i (.CLK(CLK), .RESET_N(RESET_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .FLASH_O(FLASH_O));

/* test/fbi_flash_model.sv */
// behavioural model of the parallel flash device
`timescale 1ns/10ps
module fbi_flash_model #(
	parameter logic [7:0] MFR_CODE = 8'h11, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h22, // arbitrary value
	parameter int BUSY_CYC = 30
) (
	// host pins
	input wire fbi_pkg::flash_pins_s pins,
	// device outputs
	output logic [7:0] dq_o,
	output logic dq_oe_n,
	output logic ready_busy_out
);
	logic [7:0] mem [int];
	logic [1:0] mode = 2'h0;
	logic [7:0] pend = 8'h00;
	logic [19:0] a;
	logic [7:0] d;
	logic susp = 1'h0;
	int left = 0;
	wire pd = !pins.powerdown_reset_n;
	// ****************
	// command interface
	// ****************
	always @(pd) if (pd) begin
		mode = 2'h0;
		pend = 8'h00;
		left = 0;
		susp = 1'h0;
	end
	always @(posedge pins.write_strobe_n) begin
		a = pins.address;
		d = pins.data_lines_out;
		if (!pins.chip_select_n && !pd) begin
			// clearing status leaves the read mode as it was
			if (d != 8'h50 || pend != 8'h00) mode = 2'h2;
			if (pend != 8'h00 && pins.vpp_enable) begin
				if (pend == 8'h40) begin
					mem[a] = d;
					left = BUSY_CYC;
				end else if (d == 8'hD0) begin
					foreach (mem[k]) if (k[19:16] == a[19:16]) mem[k] = 8'hFF;
					left = 4 * BUSY_CYC;
				end
				pend = 8'h00;
			end else begin
				pend = (d == 8'h40 || d == 8'h20) ? d : 8'h00;
				if (d == 8'hFF && (left == 0 || susp)) mode = 2'h0;
				if (d == 8'h90) mode = 2'h1;
				if (d == 8'hB0) susp = left > 0;
				if (d == 8'hD0) susp = 1'h0;
			end
		end
	end
	// deselect does not stop the engine, only suspend or reset do
	always #10 if (left > 0 && !susp) left--;
	assign ready_busy_out = pd || susp || left == 0;
	assign dq_oe_n = pins.chip_select_n || pins.output_gate_n || pd
		|| !pins.write_strobe_n;
	always @* begin
		case (mode)
			2'h0: dq_o = mem.exists(pins.address) ? mem[pins.address] : 8'hFF;
			2'h1: dq_o = pins.address[0] ? DEV_CODE : MFR_CODE;
			default: dq_o = {ready_busy_out, 7'h00};
		endcase
	end
endmodule

/* test/tb.sv */
// self-checking bench of the apb flash host
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary value
	localparam logic [7:0] DEV = 8'hC5; // arbitrary value
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic sup, dev_oe_n, rb;
	logic [7:0] paddr, dev_q, flip;
	logic [31:0] pwdata, prdata, rd;
	wire [7:0] dq;
	fbi_pkg::flash_pins_s pins, mp;
	int bad_count, n_checks;
	fbi_host fbi_host_i (.CLK(clk), .RESET_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FLASH_O(pins),
		.DATA_LINES_I(dq), .READY_BUSY_I(rb));
	fbi_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fbi_flash_model_i (
		.pins(mp), .dq_o(dev_q), .dq_oe_n(dev_oe_n), .ready_busy_out(rb));
	// the supply switch sits between the host request and the device
	always_comb begin
		mp = pins;
		mp.vpp_enable = pins.vpp_enable && sup;
	end
	// released lines must not keep a stale value
	assign dq = !pins.data_lines_oe_n ? pins.data_lines_out :
		!dev_oe_n ? dev_q : flip;
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) flip <= ~flip;
	task automatic chk(input logic [31:0] seen, exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wait_rb(input logic v);
		int n;
		n = 0;
		do begin
			apb(1'h0, fbi_pkg::OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[1] !== v && n < 60);
		chk(rd[1], v, "ready pin stuck");
	endtask
	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, fbi_pkg::OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'h0 && n < 500);
		chk(rd[0], 1'h0, "stuck busy");
	endtask
	task automatic run(input logic [19:0] fa, input logic [7:0] d,
		input logic [3:0] o);
		apb(1'h1, fbi_pkg::OFS_ADDR, {12'h000, fa});
		apb(1'h1, fbi_pkg::OFS_WDATA, {24'h00_0000, d});
		apb(1'h1, fbi_pkg::OFS_CTRL, {28'h000_0000, o});
		idle();
		apb(1'h0, fbi_pkg::OFS_RDATA, 32'h0000_0000);
	endtask
	task automatic s_read();
		run(20'h1_2345, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00FF, "array read after wake");
		run(20'h0_0000, 8'h00, fbi_pkg::OP_IDENT);
		chk(rd, {24'h00_0000, MFR}, "maker code");
		run(20'hF_0001, 8'h00, fbi_pkg::OP_IDENT);
		chk(rd, {24'h00_0000, DEV}, "part code");
	endtask
	task automatic s_prog();
		run(20'h2_3456, 8'h3C, fbi_pkg::OP_PROGRAM);
		run(20'h2_3456, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00FF, "altered without supply");
		sup <= 1'h1;
		run(20'h2_3456, 8'h3C, fbi_pkg::OP_PROGRAM);
		run(20'h3_4567, 8'hC3, fbi_pkg::OP_PROGRAM);
		run(20'h2_3456, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_003C, "byte not written");
	endtask
	task automatic s_erase();
		int n;
		n = 0;
		apb(1'h1, fbi_pkg::OFS_STATUS, 32'h0000_0004);
		apb(1'h1, fbi_pkg::OFS_ADDR, 32'h0002_FFFF);
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0004);
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0000);
		chk(err, 1'h1, "start accepted while busy");
		do begin
			apb(1'h0, fbi_pkg::OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[1] !== 1'h0 && n < 60);
		chk(rd[1], 1'h0, "busy pin never low");
		chk(rd[2], 1'h0, "done before end");
		idle();
		chk(rd[2], 1'h1, "done not set");
		run(20'h2_3456, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00FF, "block not erased");
		run(20'h3_4567, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00C3, "wrong block erased");
	endtask
	task automatic s_susp();
		apb(1'h1, fbi_pkg::OFS_CONFIG, 32'h0000_0002);
		run(20'h2_0010, 8'h77, fbi_pkg::OP_PROGRAM);
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0004);
		wait_rb(1'h0);
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0005);
		chk(err, 1'h0, "suspend refused");
		idle();
		chk(rd[1], 1'h1, "ready low in suspend");
		run(20'h3_4567, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00C3, "read in suspend");
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0006);
		idle();
		chk(rd[1], 1'h0, "erase not resumed");
		wait_rb(1'h1);
		run(20'h2_0010, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00FF, "resumed erase lost");
		run(20'h0_0000, 8'h00, fbi_pkg::OP_CLEAR);
		run(20'h0_0000, 8'h00, fbi_pkg::OP_STATUS);
		chk(rd, 32'h0000_0080, "status read");
	endtask
	task automatic s_pd();
		apb(1'h0, 8'h40, 32'h0000_0000);
		chk(err, 1'h1, "unmapped address accepted");
		apb(1'h1, fbi_pkg::OFS_CONFIG, 32'h0000_0001);
		apb(1'h0, fbi_pkg::OFS_STATUS, 32'h0000_0000);
		chk(rd[3:1], 3'h7, "powerdown status");
		apb(1'h1, fbi_pkg::OFS_CTRL, 32'h0000_0000);
		chk(err, 1'h1, "op started in powerdown");
		apb(1'h1, fbi_pkg::OFS_CONFIG, 32'h0000_0000);
		idle();
		run(20'h3_4567, 8'h00, fbi_pkg::OP_READ);
		chk(rd, 32'h0000_00C3, "array mode after wake");
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, sup, paddr, pwdata} = '0;
		{flip, bad_count, n_checks} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		idle();
		s_read();
		s_prog();
		s_erase();
		s_susp();
		s_pd();
		wrap_up();
	end
	// far beyond the expected run length of about twelve hundred cycles
	initial begin
		#500_000;
		bad_count++;
		wrap_up();
	end
endmodule
